// ===== design/bpx_pkg.sv
// Constants for the bidirectional port with external interrupt lines.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// ---------------------------------------------------------------------
// Overview of operation
// RQ1 - Up to eight pins, each input with or without interrupt, or output.
// RQ2 - Bit n of data, direction and option registers belongs to pin n.
// RQ3 - Direction clear: pin is input and data read returns pin level.
// RQ4 - Data write on an input pin only updates the latch.
// RQ5 - Input option bit picks floating or pull-up; pull-up only then.
// RQ6 - Interrupt input raises a request on an event matching its sensitivity.
// RQ7 - Each interrupt line has its own sensitivity field in a control register.
// RQ8 - Enabled pins sharing a line are ANDed before edge detection.
// RQ9 - Vector fetch by the CPU clears the pending request latch.
// RQ10 - A write changing a line's sensitivity clears its pending request.
// RQ11 - Disabled pin feeds logic 1 to the edge detector.
// RQ12 - Software enables interrupts via rising edge, option set, then sensitivity.
// RQ13 - Software disables via falling edge, option clear, then rising edge.
// RQ14 - Direction set: pin driven from latch; read returns latch value.
// RQ15 - Output option picks push-pull or open-drain; zero drives low.
// RQ16 - Software writes data before switching a pin to output.
// RQ17 - Peripheral output overrides port and forces pin to output.
// RQ18 - Peripheral input pins are floating inputs, still readable.
// RQ19 - Input pin with peripheral output enabled reads peripheral output.
// RQ20 - Output pin feeding peripheral input gives it the data latch.
// RQ21 - Software keeps alternate function off on interrupt inputs.
// RQ22 - Analog inputs are floating; software keeps pins quiet meanwhile.
// RQ23 - Request reaches CPU only on interrupt input with mask clear.
// RQ24 - Pins are synchronised before edge detection.
// ---------------------------------------------------------------------
package bpx_pkg;

  // Register offsets
  localparam logic [1:0] BPX_OFS_DATA = 2'h0;
  localparam logic [1:0] BPX_OFS_DIR  = 2'h1;
  localparam logic [1:0] BPX_OFS_OPT  = 2'h2;
  localparam logic [1:0] BPX_OFS_SENS = 2'h3;

  // Reset values
  localparam logic [7:0] BPX_RST_DATA = 8'h00;
  localparam logic [7:0] BPX_RST_DIR  = 8'h00;
  localparam logic [7:0] BPX_RST_OPT  = 8'h00;
  localparam logic [7:0] BPX_RST_SENS = 8'h00;

  // Sensitivity field width and codes
  localparam int         BPX_SENS_W       = 2;
  localparam logic [1:0] BPX_SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] BPX_SENS_RISE     = 2'h1;
  localparam logic [1:0] BPX_SENS_FALL     = 2'h2;
  localparam logic [1:0] BPX_SENS_BOTH     = 2'h3;

endpackage

// ===== design/bpx_port.sv
// Bidirectional port: data, direction, option and sensitivity registers,
// pin drivers, alternate-function override and external interrupt lines.
// Assumes pins are asynchronous and the CPU supplies mask and vector fetch.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module bpx_port
  import bpx_pkg::*;
#(
  parameter int         WIDTH      = 8,
  parameter int         NUM_IRQ    = 2,
  parameter logic [7:0] IRQ_GRP0   = 8'h01,
  parameter logic [7:0] IRQ_GRP1   = 8'h80
) (
  // Clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               SRST,
  // Register port
  input  wire logic [1:0]         ADDR,
  input  wire logic [7:0]         WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [7:0]         RDATA,
  // Pins
  input  wire logic [WIDTH-1:0]   PIN_I,
  output logic      [WIDTH-1:0]   PIN_O,
  output logic      [WIDTH-1:0]   PIN_OE,
  output logic      [WIDTH-1:0]   PIN_PULLUP,
  // Alternate functions
  input  wire logic [WIDTH-1:0]   ALT_OUT_EN,
  input  wire logic [WIDTH-1:0]   ALT_OUT,
  input  wire logic [WIDTH-1:0]   ALT_OPEN_DRAIN,
  output logic      [WIDTH-1:0]   ALT_IN,
  // CPU interrupt side
  input  wire logic               CPU_IRQ_MASK,
  input  wire logic [NUM_IRQ-1:0] VEC_FETCH,
  output logic      [NUM_IRQ-1:0] IRQ_REQ
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] data_q, dir_q, opt_q;
  logic [7:0]       sens_q;
  logic [WIDTH-1:0] sync1_q, sync2_q;
  logic [NUM_IRQ-1:0] lvl_prev_q, pend_q;
  logic [NUM_IRQ-1:0] grp_lvl;
  logic [WIDTH-1:0] irq_pin_en;
  logic [WIDTH-1:0] rd_val;

  function automatic logic [1:0] sens_field(input logic [7:0] v, input int g);
    sens_field = v[g*BPX_SENS_W +: BPX_SENS_W];
  endfunction

  function automatic logic [7:0] grp_mask(input int g);
    grp_mask = (g == 0) ? IRQ_GRP0 : IRQ_GRP1;
  endfunction

  wire wr_data = WR && (ADDR == BPX_OFS_DATA);
  wire wr_dir  = WR && (ADDR == BPX_OFS_DIR);
  wire wr_opt  = WR && (ADDR == BPX_OFS_OPT);
  wire wr_sens = WR && (ADDR == BPX_OFS_SENS);

  // Latch written whatever the direction; pin follows only in output [RQ2] [RQ4]
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      data_q <= WIDTH'(BPX_RST_DATA);
    end else if (wr_data) begin
      data_q <= WDATA[WIDTH-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      dir_q <= WIDTH'(BPX_RST_DIR);
      opt_q <= WIDTH'(BPX_RST_OPT);
    end else begin
      if (wr_dir) begin
        dir_q <= WDATA[WIDTH-1:0]; // [RQ1]
      end
      if (wr_opt) begin
        opt_q <= WDATA[WIDTH-1:0];
      end
    end
  end

  // Independent sensitivity per line [RQ7]
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sens_q <= BPX_RST_SENS;
    end else if (wr_sens) begin
      sens_q <= WDATA;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= PIN_I;
      sync2_q <= sync1_q; // [RQ24]
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PIN_O      <= '0;
      PIN_OE     <= '0;
      PIN_PULLUP <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (ALT_OUT_EN[i]) begin
          // Peripheral takes the pin as output [RQ17]
          PIN_O[i]      <= ALT_OUT[i];
          PIN_OE[i]     <= ALT_OPEN_DRAIN[i] ? ~ALT_OUT[i] : 1'b1;
          PIN_PULLUP[i] <= 1'b0;
        end else if (dir_q[i]) begin
          // Option set is push-pull, clear is open-drain [RQ14] [RQ15]
          PIN_O[i]      <= data_q[i];
          PIN_OE[i]     <= opt_q[i] ? 1'b1 : ~data_q[i];
          PIN_PULLUP[i] <= 1'b0;
        end else begin
          PIN_O[i]      <= 1'b0;
          PIN_OE[i]     <= 1'b0; // [RQ3]
          PIN_PULLUP[i] <= opt_q[i]; // [RQ5]
        end
      end
    end
  end

  // Peripheral input sees latch on outputs, pin on inputs [RQ20] [RQ18]
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ALT_IN <= '1;
    end else begin
      ALT_IN <= (dir_q & data_q) | (~dir_q & sync2_q);
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (dir_q[i]) begin
        rd_val[i] = data_q[i]; // [RQ14]
      end else if (ALT_OUT_EN[i]) begin
        rd_val[i] = ALT_OUT[i]; // [RQ19]
      end else begin
        rd_val[i] = sync2_q[i]; // [RQ3] [RQ18]
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else if (!RD) begin
      RDATA <= 8'h00;
    end else if (ADDR == BPX_OFS_DATA) begin
      RDATA <= 8'(rd_val);
    end else if (ADDR == BPX_OFS_DIR) begin
      RDATA <= 8'(dir_q);
    end else if (ADDR == BPX_OFS_OPT) begin
      RDATA <= 8'(opt_q);
    end else begin
      RDATA <= sens_q;
    end
  end

  // ---------------------------------------------------------------
  // External interrupt lines
  // ---------------------------------------------------------------
  assign irq_pin_en = ~dir_q & opt_q;

  generate
    for (genvar g = 0; g < NUM_IRQ; g++) begin : g_irq
      logic [WIDTH-1:0] pin_lvl;
      logic [1:0]       sens;
      logic             ev;
      logic             sens_chg;

      // Disabled pins read as one; enabled pins ANDed [RQ11] [RQ8]
      assign pin_lvl    = sync2_q | ~irq_pin_en | ~WIDTH'(grp_mask(g));
      assign grp_lvl[g] = &pin_lvl;
      assign sens       = sens_field(sens_q, g);
      assign sens_chg   = wr_sens && (sens_field(WDATA, g) != sens);

      always_comb begin
        case (sens)
          BPX_SENS_FALL_LOW: ev = ~grp_lvl[g];
          BPX_SENS_RISE:     ev = grp_lvl[g] & ~lvl_prev_q[g];
          BPX_SENS_FALL:     ev = ~grp_lvl[g] & lvl_prev_q[g];
          default:           ev = grp_lvl[g] ^ lvl_prev_q[g];
        endcase
      end

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          lvl_prev_q[g] <= 1'b1;
        end else begin
          lvl_prev_q[g] <= grp_lvl[g]; // [RQ24]
        end
      end

      // New event wins over a clear in the same cycle
      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          pend_q[g] <= 1'b0;
        end else if (ev) begin
          pend_q[g] <= 1'b1; // [RQ6]
        end else if (VEC_FETCH[g] || sens_chg) begin
          pend_q[g] <= 1'b0; // [RQ9] [RQ10]
        end
      end

      assign IRQ_REQ[g] = pend_q[g] & ~CPU_IRQ_MASK; // [RQ23]
    end
  endgenerate

endmodule

// ===== dv/bpx_pins.sv
// Pin pads of the port: port drive, far-side source and pull-up.
// Assumes one clock; a pin nobody drives toggles every cycle.
`timescale 1ns/1ns
module bpx_pins (
  input  wire logic       clk,
  input  wire logic [7:0] o, oe, pu, ext_en, ext_v,
  output logic      [7:0] lvl
);
  logic [7:0] flt_q = 8'h00;
  always_ff @(posedge clk) begin
    flt_q <= ~lvl;
  end
  // Open-drain high leaves the pin to the far side or the pull-up
  always_comb lvl = (oe & o) | (~oe & ext_en & ext_v) | (~oe & ~ext_en & (pu | flt_q));
endmodule

// ===== dv/bpx_port_asserts.sv
// Assertions on the ports of bpx_port.
// Bound to every bpx_port instance; sees its ports only.
`timescale 1ns/1ns
module bpx_port_asserts
  import bpx_pkg::*;
#(parameter int WIDTH = 8, parameter int NUM_IRQ = 2) (
  input wire logic               REF_CLK, SRST, WR, RD, CPU_IRQ_MASK,
  input wire logic [1:0]         ADDR,
  input wire logic [7:0]         WDATA, RDATA,
  input wire logic [WIDTH-1:0]   PIN_I, PIN_O, PIN_OE, PIN_PULLUP, ALT_OUT_EN, ALT_OUT, ALT_OPEN_DRAIN, ALT_IN,
  input wire logic [NUM_IRQ-1:0] VEC_FETCH, IRQ_REQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  a_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata not idle");
  a_dir_back: assert property (WR && ADDR == BPX_OFS_DIR ##1 RD && ADDR == BPX_OFS_DIR
    |=> RDATA == $past(WDATA, 2)) else $error("direction readback");
  a_pu_input: assert property ((PIN_PULLUP & PIN_OE) == '0) else $error("pull-up on driven pin");
  a_in_float: assert property (WR && ADDR == BPX_OFS_DIR && WDATA == 8'h00 && ALT_OUT_EN == '0
    ##1 ALT_OUT_EN == '0 [*2] |=> PIN_OE == '0) else $error("input pin driven");
  a_alt_pp: assert property (ALT_OUT_EN[0] && !ALT_OPEN_DRAIN[0]
    |=> PIN_OE[0] && PIN_O[0] == $past(ALT_OUT[0])) else $error("alt push-pull");
  a_alt_od: assert property (ALT_OUT_EN[1] && ALT_OPEN_DRAIN[1] |=> PIN_OE[1] == !$past(ALT_OUT[1]))
    else $error("alt open-drain");
  a_req_mask: assert property (CPU_IRQ_MASK |-> IRQ_REQ == '0) else $error("masked request shown");
  a_fetch_clr: assert property (VEC_FETCH[0] && !$past(WR) && PIN_I[0] && $past(PIN_I[0])
    && $past(PIN_I[0], 2) && $past(PIN_I[0], 3) |=> !IRQ_REQ[0]) else $error("fetch left request");
endmodule
bind bpx_port bpx_port_asserts #(.WIDTH(WIDTH), .NUM_IRQ(NUM_IRQ)) u_chk (.*);

// ===== dv/tb_top.sv
// Self-checking bench for bpx_port: registers, pins, alternates, interrupts.
// Assumes the pad model bpx_pins and the bound checker.
`timescale 1ns/1ns
module tb_top
  import bpx_pkg::*;
;
  logic        clk = 0, srst = 1, wr = 0, rd = 0, mask = 0, rd_seen = 0;
  logic [1:0]  addr = '0, vf = '0, irq;
  logic [7:0]  wdata = '0, rdata, pin_i, pin_o, pin_oe, pin_pu, alt_in;
  logic [7:0]  aen = '0, aout = '0, aod = '0, ext_en = 8'hff, ext_v = 8'hff;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'd43222;
  int          fails = 0, tests_run = 0;

  initial forever #20 clk = ~clk;

  bpx_port uut (.REF_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu), .ALT_OUT_EN(aen), .ALT_OUT(aout),
    .ALT_OPEN_DRAIN(aod), .ALT_IN(alt_in), .CPU_IRQ_MASK(mask), .VEC_FETCH(vf), .IRQ_REQ(irq));
  bpx_pins u_pins (.clk(clk), .o(pin_o), .oe(pin_oe), .pu(pin_pu), .ext_en(ext_en), .ext_v(ext_v), .lvl(pin_i));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    wr <= 1'b1; rd <= 1'b0; addr <= a; wdata <= d;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [1:0] a, input logic [7:0] e);
    wr <= 1'b0; rd <= 1'b1; addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0; rd <= 1'b0; vf <= 2'h0;
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for request line 0 to reach a level
  task automatic wirq(input logic e);
    int k;
    for (k = 0; k < 8 && irq[0] !== e; k++) @(posedge clk);
    chk("irq0", irq[0], e);
    if (irq[0] !== e) close_out();
  endtask

  // Read data appear one cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk("rdata", rdata, exp_q.pop_front());
    rd_seen <= rd;
  end

  initial begin
    logic [7:0] d, v;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    idle(1);
    for (int i = 0; i < 4; i++) rdr(i[1:0], (i == 0) ? 8'hff : 8'h00);
    d = rnd();
    wrr(BPX_OFS_DATA, d);
    wrr(BPX_OFS_OPT, 8'h0f);
    wrr(BPX_OFS_DIR, 8'hff);
    rdr(BPX_OFS_DIR, 8'hff);
    rdr(BPX_OFS_DATA, d);
    idle(3);
    chk("pin_o", pin_o, d);
    chk("pin_oe", pin_oe, 8'h0f | ~d);
    chk("alt_in", alt_in, d);
    v = rnd();
    ext_en <= 8'h0f;
    ext_v <= v;
    wrr(BPX_OFS_OPT, 8'hf0);
    wrr(BPX_OFS_DIR, 8'h00);
    wrr(BPX_OFS_DATA, ~d);
    idle(4);
    rdr(BPX_OFS_DATA, {4'hf, v[3:0]});
    idle(1);
    chk("pin_oe", pin_oe, 8'h00);
    chk("pin_pu", pin_pu, 8'hf0);
    wrr(BPX_OFS_DIR, 8'hff);
    rdr(BPX_OFS_DATA, ~d);
    wrr(BPX_OFS_DIR, 8'h00);
    aen <= 8'h03; aout <= 8'h02; aod <= 8'h02;
    idle(4);
    rdr(BPX_OFS_DATA, {4'hf, v[3:2], 2'h2});
    idle(1);
    chk("pin_oe", pin_oe, 8'h01);
    aen <= 8'h00;
    ext_v <= 8'hff;
    mask <= 1'b1;
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_RISE});
    wrr(BPX_OFS_OPT, 8'hf1);
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_FALL});
    ext_v <= 8'hfe;
    idle(6);
    chk("irq0", irq[0], 1'b0);
    mask <= 1'b0;
    wirq(1'b1);
    ext_v <= 8'hff;
    idle(5);
    vf <= 2'h1;
    @(posedge clk);
    idle(2);
    chk("irq0", irq[0], 1'b0);
    ext_v <= 8'hfe;
    wirq(1'b1);
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_RISE});
    idle(1);
    chk("irq0", irq[0], 1'b0);
    wrr(BPX_OFS_OPT, 8'hf0);
    idle(1);
    wirq(1'b1);
    // Safe enable then safe disable with the pin held low
    mask <= 1'b1;
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_FALL});
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_RISE});
    wrr(BPX_OFS_OPT, 8'hf1);
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_FALL});
    wrr(BPX_OFS_OPT, 8'hf0);
    wrr(BPX_OFS_SENS, {6'h0, BPX_SENS_RISE});
    idle(4);
    mask <= 1'b0;
    idle(2);
    chk("irq0", irq[0], 1'b0);
    for (int c = 0; c < 4; c++) begin
      wrr(BPX_OFS_SENS, c[7:0]);
      rdr(BPX_OFS_SENS, c[7:0]);
    end
    idle(3);
    close_out();
  end
endmodule
